// File: rtl/ctt_core.sv
// Purpose: CAN timeout down-counter and tx buffer add-request logic,
//          with an APB register slave and one level interrupt.
// Assumes: bit_tick pulses once per CAN bit time; scan and tx result
//          inputs come from controller logic on pclk.
// Notes: APB answers with one wait state; pslverr on unmapped offsets.
//
// Local design decision: the APB slave port.
module ctt_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input ctt_pkg::ctt_apb_req_t apb_req,
	output ctt_pkg::ctt_apb_rsp_t apb_rsp,
	// Bit timing and timeout start events
	input wire logic bit_tick,
	input wire logic tx_event,
	input wire logic rx_event,
	// Tx scan and transmission results
	input wire logic tx_scan_busy,
	input wire logic tx_scan_done,
	input wire logic [31:0] tx_success,
	input wire logic [31:0] tx_fail,
	// Buffer state towards the scan engine
	output logic [31:0] tx_request_pending,
	output logic [31:0] tx_cancel_finished,
	// Interrupt
	output logic irq
);
	import ctt_pkg::*;

	ctt_state_t s_q;
	ctt_state_t s_d;

	logic acc;
	logic wr;
	logic rd;
	logic cntval_wr;
	logic add_wr;
	logic start_evt;
	logic too_set;
	logic xfer;
	logic [NBUF-1:0] new_add;
	logic [NBUF-1:0] moved;
	logic [NBUF-1:0] cfin_set;
	logic [INT_W-1:0] int_clr;
	logic [31:0] rdata;

	function automatic logic hit(input logic [AW-1:0] a,
		input logic [AW-1:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic mapped(input logic [AW-1:0] a);
		return hit(a, CNTVAL_OFS) | hit(a, ADD_OFS) | hit(a, CTRL_OFS) |
			hit(a, RELOAD_OFS) | hit(a, TXCFG_OFS) | hit(a, PEND_OFS) |
			hit(a, CFIN_OFS) | hit(a, ISTAT_OFS) | hit(a, IMASK_OFS);
	endfunction

	// Bus access completes on the edge where pready is seen high
	assign acc = apb_req.psel & apb_req.penable & s_q.rsp.pready;
	assign wr = acc & apb_req.pwrite;
	assign rd = acc & ~apb_req.pwrite;
	assign cntval_wr = wr & hit(apb_req.paddr, CNTVAL_OFS);
	assign add_wr = wr & hit(apb_req.paddr, ADD_OFS);

	always_comb begin
		unique case (s_q.ctrl.timeout_select)
			SEL_CONT: start_evt = 1'b0;
			SEL_TXEV: start_evt = tx_event;
			SEL_RXEV: start_evt = rx_event;
			SEL_ANYEV: start_evt = tx_event | rx_event;
		endcase
	end

	// Add requests go to pending only while no scan runs or as one ends
	assign xfer = ~tx_scan_busy | tx_scan_done;
	assign moved = xfer ? s_q.add_request_bits : '0;
	assign new_add = add_wr ? (apb_req.pwdata & s_q.tx_buffer_config &
		~s_q.tx_request_pending) : '0;
	assign cfin_set = s_q.ctrl.no_auto_retransmit_mode ?
		(tx_fail & s_q.tx_request_pending) : '0;
	// Clear only flags that the completed read returned
	assign int_clr = (rd && hit(apb_req.paddr, ISTAT_OFS)) ?
		s_q.rsp.prdata[INT_W-1:0] : '0;

	always_comb begin
		rdata = '0;
		case (apb_req.paddr)
			CNTVAL_OFS: rdata[15:0] = s_q.timeout_count;
			ADD_OFS: rdata = s_q.add_request_bits;
			CTRL_OFS: rdata = s_q.ctrl;
			RELOAD_OFS: rdata[15:0] = s_q.reload;
			TXCFG_OFS: rdata = s_q.tx_buffer_config;
			PEND_OFS: rdata = s_q.tx_request_pending;
			CFIN_OFS: rdata = s_q.tx_cancel_finished;
			ISTAT_OFS: rdata[INT_W-1:0] = s_q.int_flags;
			IMASK_OFS: rdata[INT_W-1:0] = s_q.int_mask;
			default: rdata = '0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		too_set = 1'b0;

		// Timeout counter
		unique case (s_q.st)
			TMO_IDLE: begin
				if (s_q.ctrl.timeout_select == SEL_CONT || start_evt) begin
					s_d.st = TMO_RUN;
					s_d.timeout_count = s_q.reload;
					s_d.presc = '0;
				end
			end
			TMO_RUN: begin
				if (start_evt) begin
					s_d.timeout_count = s_q.reload;
					s_d.presc = '0;
				end else if (s_q.timeout_count == '0) begin
					s_d.st = TMO_DONE;
					too_set = 1'b1;
				end else if (bit_tick) begin
					if (s_q.presc == s_q.ctrl.timeout_prescaler) begin
						s_d.presc = '0;
						s_d.timeout_count = 16'(s_q.timeout_count - 16'h1);
						if (s_d.timeout_count == '0) begin
							s_d.st = TMO_DONE;
							too_set = 1'b1;
						end
					end else begin
						s_d.presc = 4'(s_q.presc + 4'h1);
					end
				end
			end
			TMO_DONE: begin
				if (start_evt) begin
					s_d.st = TMO_RUN;
					s_d.timeout_count = s_q.reload;
					s_d.presc = '0;
				end
			end
			default: s_d.st = TMO_IDLE;
		endcase
		if (cntval_wr) begin
			s_d.timeout_count = s_q.reload;
			s_d.presc = '0;
			too_set = 1'b0;
			if (s_q.ctrl.timeout_select == SEL_CONT) begin
				s_d.st = TMO_RUN;
			end else if (s_q.st == TMO_DONE) begin
				s_d.st = TMO_IDLE;
			end else begin
				// A reload racing expiry keeps the counter running
				s_d.st = s_q.st;
			end
		end
		if (!s_q.ctrl.timeout_enable) begin
			s_d.st = TMO_IDLE;
			too_set = 1'b0;
		end

		// Add requests, pending and cancellation
		s_d.add_request_bits = (xfer ? '0 : s_q.add_request_bits) |
			new_add;
		s_d.tx_request_pending = (s_q.tx_request_pending & ~tx_success &
			~cfin_set) | moved;
		s_d.tx_cancel_finished = (s_q.tx_cancel_finished & ~moved) |
			cfin_set;

		// Interrupt flags: a set in the clearing cycle wins
		s_d.int_flags = s_q.int_flags & ~int_clr;
		s_d.int_flags[INT_TMO] = s_d.int_flags[INT_TMO] | too_set;
		s_d.int_flags[INT_CFIN] = s_d.int_flags[INT_CFIN] | (|cfin_set);

		// Software-written registers
		if (wr) begin
			if (hit(apb_req.paddr, CTRL_OFS)) begin
				s_d.ctrl = apb_req.pwdata;
				s_d.ctrl.rsvd_hi = '0;
				s_d.ctrl.rsvd_lo = '0;
			end
			if (hit(apb_req.paddr, RELOAD_OFS)) begin
				s_d.reload = apb_req.pwdata[15:0];
			end
			if (hit(apb_req.paddr, TXCFG_OFS)) begin
				s_d.tx_buffer_config = apb_req.pwdata;
			end
			if (hit(apb_req.paddr, IMASK_OFS)) begin
				s_d.int_mask = apb_req.pwdata[INT_W-1:0];
			end
		end
		s_d.irq = |(s_d.int_flags & s_d.int_mask);

		// APB answer one cycle into the access phase
		s_d.rsp.pready = apb_req.psel & apb_req.penable & ~s_q.rsp.pready;
		s_d.rsp.prdata = (s_d.rsp.pready && !apb_req.pwrite) ? rdata : '0;
		s_d.rsp.pslverr = s_d.rsp.pready & ~mapped(apb_req.paddr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp = s_q.rsp;
	assign tx_request_pending = s_q.tx_request_pending;
	assign tx_cancel_finished = s_q.tx_cancel_finished;
	assign irq = s_q.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_cntval_reload;
		cntval_wr |=> s_q.timeout_count == $past(s_q.reload);
	endproperty
	a_cntval_reload: assert property (p_cntval_reload)
		else $error("timeout counter not reloaded on write");

	property p_presc_hold;
		(s_q.st == TMO_RUN && s_q.timeout_count != '0 && !start_evt &&
			!cntval_wr && !bit_tick) |=>
			$stable(s_q.timeout_count) && $stable(s_q.presc);
	endproperty
	a_presc_hold: assert property (p_presc_hold)
		else $error("timeout counter moved without a bit tick");

	property p_step;
		(s_q.st == TMO_RUN && bit_tick && !start_evt && !cntval_wr &&
			s_q.ctrl.timeout_enable && s_q.timeout_count > 16'h1 &&
			s_q.presc == s_q.ctrl.timeout_prescaler) |=>
			s_q.timeout_count == $past(s_q.timeout_count) - 16'h1 &&
			s_q.presc == '0;
	endproperty
	a_step: assert property (p_step)
		else $error("timeout counter missed its prescaled step");

	property p_expire;
		(s_q.st == TMO_RUN && bit_tick && !start_evt && !cntval_wr &&
			s_q.ctrl.timeout_enable && s_q.timeout_count == 16'h1 &&
			s_q.presc == s_q.ctrl.timeout_prescaler) |=>
			s_q.st == TMO_DONE && s_q.timeout_count == '0 &&
			s_q.int_flags[INT_TMO];
	endproperty
	a_expire: assert property (p_expire)
		else $error("timeout expiry did not flag and stop");

	property p_hold_zero;
		(s_q.st == TMO_DONE && !start_evt && !cntval_wr) [*2] |->
			s_q.timeout_count == '0 && $stable(s_q.timeout_count);
	endproperty
	a_hold_zero: assert property (p_hold_zero)
		else $error("stopped timeout counter is not held at zero");

	property p_select;
		(s_q.st == TMO_IDLE && s_q.ctrl.timeout_select != SEL_CONT &&
			!start_evt && !cntval_wr) |=> s_q.st == TMO_IDLE;
	endproperty
	a_select: assert property (p_select)
		else $error("timeout counter started without its event");

	property p_cancel;
		(s_q.ctrl.no_auto_retransmit_mode &&
			|(tx_fail & s_q.tx_request_pending)) |=>
			(s_q.tx_request_pending &
			$past(tx_fail & s_q.tx_request_pending)) == '0;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("failed transmission still pending");

	property p_cfin;
		(s_q.ctrl.no_auto_retransmit_mode &&
			|(tx_fail & s_q.tx_request_pending)) |=>
			s_q.int_flags[INT_CFIN] &&
			(s_q.tx_cancel_finished & $past(tx_fail)) != '0;
	endproperty
	a_cfin: assert property (p_cfin)
		else $error("cancel finished not set for failed buffer");

	property p_ignore;
		add_wr |=> (s_q.add_request_bits & $past(apb_req.pwdata &
			s_q.tx_request_pending & ~s_q.add_request_bits)) == '0;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("add request accepted for a pending buffer");

	property p_w1s;
		(add_wr && !xfer) |=> s_q.add_request_bits == ($past(
			s_q.add_request_bits) | $past(apb_req.pwdata &
			s_q.tx_buffer_config & ~s_q.tx_request_pending));
	endproperty
	a_w1s: assert property (p_w1s)
		else $error("add request bits not set one for one");

	property p_cfg_only;
		##1 ((s_q.add_request_bits & ~$past(s_q.add_request_bits)) &
			~$past(s_q.tx_buffer_config)) == '0;
	endproperty
	a_cfg_only: assert property (p_cfg_only)
		else $error("add request set for an unconfigured buffer");

	property p_clear;
		(xfer && !add_wr) |=> s_q.add_request_bits == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("add request bits not cleared when scan idle");

	property p_hold_busy;
		(tx_scan_busy && !tx_scan_done) |=>
			(s_q.add_request_bits & $past(s_q.add_request_bits)) ==
			$past(s_q.add_request_bits);
	endproperty
	a_hold_busy: assert property (p_hold_busy)
		else $error("add request bits dropped during a scan");

	property p_pending;
		(xfer && s_q.add_request_bits != '0) |=>
			(s_q.tx_request_pending & $past(s_q.add_request_bits)) ==
			$past(s_q.add_request_bits);
	endproperty
	a_pending: assert property (p_pending)
		else $error("accepted add request did not set pending");

	property p_disable;
		!s_q.ctrl.timeout_enable |=> s_q.st == TMO_IDLE;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disabled timeout counter left the idle state");

	property p_done_flag;
		(s_q.st != TMO_DONE) ##1 (s_q.st == TMO_DONE) |->
			s_q.int_flags[INT_TMO];
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("timeout stop reached without its flag");

	property p_ready_pulse;
		s_q.rsp.pready |=> !s_q.rsp.pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("bus ready held for more than one cycle");

	property p_err_map;
		acc |-> s_q.rsp.pslverr == !mapped(apb_req.paddr);
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("bus error flag does not match the address map");

endmodule

// File: inc/ctt_pkg.sv
// Purpose: constants, register map and types of the CAN timeout and
//          tx add-request block.
// Assumes: APB with 32-bit data; all block inputs are on pclk.
package ctt_pkg;

	localparam int NBUF = 32;
	localparam int AW = 12;

	// Register byte offsets
	localparam logic [AW-1:0] CNTVAL_OFS = 12'h02C;
	localparam logic [AW-1:0] ADD_OFS = 12'h0D0;
	localparam logic [AW-1:0] CTRL_OFS = 12'h100;
	localparam logic [AW-1:0] RELOAD_OFS = 12'h104;
	localparam logic [AW-1:0] TXCFG_OFS = 12'h108;
	localparam logic [AW-1:0] PEND_OFS = 12'h10C;
	localparam logic [AW-1:0] CFIN_OFS = 12'h110;
	localparam logic [AW-1:0] ISTAT_OFS = 12'h114;
	localparam logic [AW-1:0] IMASK_OFS = 12'h118;

	localparam logic [15:0] CNTVAL_RST = 16'hFFFF;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;

	// Interrupt status and mask bit positions
	localparam int INT_W = 2;
	localparam int INT_TMO = 0;
	localparam int INT_CFIN = 1;

	typedef enum logic [1:0] {
		SEL_CONT = 2'h0,
		SEL_TXEV = 2'h1,
		SEL_RXEV = 2'h2,
		SEL_ANYEV = 2'h3
	} ctt_sel_t;

	typedef enum logic [2:0] {
		TMO_IDLE = 3'h1,
		TMO_RUN = 3'h2,
		TMO_DONE = 3'h4
	} ctt_tmo_t;

	typedef struct packed {
		logic [21:0] rsvd_hi;
		logic no_auto_retransmit_mode;
		logic timeout_enable;
		logic [1:0] rsvd_lo;
		ctt_sel_t timeout_select;
		logic [3:0] timeout_prescaler;
	} ctt_ctrl_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [AW-1:0] paddr;
		logic [31:0] pwdata;
	} ctt_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ctt_apb_rsp_t;

	typedef struct packed {
		ctt_tmo_t st;
		logic [15:0] timeout_count;
		logic [3:0] presc;
		ctt_ctrl_t ctrl;
		logic [15:0] reload;
		logic [NBUF-1:0] tx_buffer_config;
		logic [NBUF-1:0] add_request_bits;
		logic [NBUF-1:0] tx_request_pending;
		logic [NBUF-1:0] tx_cancel_finished;
		logic [INT_W-1:0] int_flags;
		logic [INT_W-1:0] int_mask;
		ctt_apb_rsp_t rsp;
		logic irq;
	} ctt_state_t;

	localparam ctt_state_t STATE_RST = '{
		st: TMO_IDLE,
		timeout_count: CNTVAL_RST,
		presc: '0,
		ctrl: '{timeout_select: SEL_CONT, default: '0},
		reload: RELOAD_RST,
		rsp: '0,
		default: '0
	};

endpackage

// File: verif/ctt_scan_model.sv
// Purpose: far-side stand-in giving bit timing, tx scan and tx results.
// Assumes: everything runs on pclk; the bench steers it by levels.
// Notes: results cover pending buffers only; a round with failures
//        reports no successes, so the other buffers stay pending.
module ctt_scan_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench controls
	input wire logic tick_on,
	input wire logic scan_hold,
	input wire logic res_go,
	input wire logic [31:0] fail_sel,
	// Block side
	input wire logic [31:0] tx_request_pending,
	output logic bit_tick,
	output logic tx_scan_busy,
	output logic tx_scan_done,
	output logic [31:0] tx_success,
	output logic [31:0] tx_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'h0;
			bit_tick <= 1'b0;
			tx_scan_busy <= 1'b0;
			tx_scan_done <= 1'b0;
			tx_success <= 32'h0;
			tx_fail <= 32'h0;
		end else begin
			div_q <= div_q + 2'h1;
			// One bit time every four clocks, only while enabled
			bit_tick <= tick_on && (div_q == 2'h3);
			tx_scan_busy <= scan_hold;
			tx_scan_done <= tx_scan_busy && !scan_hold;
			tx_success <= (res_go && fail_sel == 32'h0) ?
				tx_request_pending : 32'h0;
			tx_fail <= res_go ? (tx_request_pending & fail_sel) : 32'h0;
		end
	end
endmodule

// File: verif/ctt_core_bench.sv
// Purpose: self-checking bench of the timeout and tx add-request block.
// Assumes: the APB slave answers in its own time; far side is a model.
// Notes: one bit time is four clocks; expectations follow the prescaler.
module ctt_core_bench import ctt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, tick_on, scan_hold, res_go, tx_event, rx_event;
	logic bit_tick, tx_scan_busy, tx_scan_done, irq, e;
	logic [31:0] fail_sel, tx_success, tx_fail, pend, cfin, rd, n;
	ctt_apb_req_t req;
	ctt_apb_rsp_t rsp;
	int err_total, compares;

	ctt_core u_ctt_core (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .bit_tick(bit_tick), .tx_event(tx_event),
		.rx_event(rx_event), .tx_scan_busy(tx_scan_busy),
		.tx_scan_done(tx_scan_done), .tx_success(tx_success),
		.tx_fail(tx_fail), .tx_request_pending(pend),
		.tx_cancel_finished(cfin), .irq(irq));
	ctt_scan_model u_ctt_scan_model (.pclk(pclk), .presetn(presetn),
		.tick_on(tick_on), .scan_hold(scan_hold), .res_go(res_go),
		.fail_sel(fail_sel), .tx_request_pending(pend),
		.bit_tick(bit_tick), .tx_scan_busy(tx_scan_busy),
		.tx_scan_done(tx_scan_done), .tx_success(tx_success),
		.tx_fail(tx_fail));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task test_done;
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		chk({31'h0, rsp.pready}, 32'h00000001);
		rd = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task wr(input logic [AW-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [AW-1:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask

	task res(input logic [31:0] f);
		fail_sel <= f;
		res_go <= 1'b1;
		cyc(1);
		res_go <= 1'b0;
		cyc(3);
	endtask

	task cnt_ticks;
		int k;
		n = 32'h0;
		k = 0;
		tick_on <= 1'b1;
		while (irq !== 1'b1 && k < 2000) begin
			@(posedge pclk);
			if (bit_tick === 1'b1) n = n + 32'h1;
			k++;
		end
	endtask

	task t_reset;
		rdchk(CNTVAL_OFS, 32'h0000FFFF);
		rdchk(ADD_OFS, 32'h00000000);
		apb(1'b0, 12'h0FC, 32'h0);
		chk({31'h0, e}, 32'h00000001);
		chk(rd, 32'h00000000);
	endtask

	task t_add;
		wr(TXCFG_OFS, 32'h000000FF);
		wr(ADD_OFS, 32'hFFFF0081);
		cyc(3);
		chk(pend, 32'h00000081);
		rdchk(ADD_OFS, 32'h00000000);
		scan_hold <= 1'b1;
		cyc(2);
		wr(ADD_OFS, 32'h00000003);
		rdchk(ADD_OFS, 32'h00000002);
		wr(ADD_OFS, 32'h00000000);
		rdchk(ADD_OFS, 32'h00000002);
		chk(pend, 32'h00000081);
		scan_hold <= 1'b0;
		cyc(4);
		chk(pend, 32'h00000083);
		rdchk(ADD_OFS, 32'h00000000);
	endtask

	task t_cancel;
		wr(IMASK_OFS, 32'h00000002);
		wr(CTRL_OFS, 32'h00000200);
		res(32'h00000001);
		chk(cfin, 32'h00000001);
		chk(pend, 32'h00000082);
		chk({31'h0, irq}, 32'h00000001);
		rdchk(ISTAT_OFS, 32'h00000002);
		cyc(1);
		chk({31'h0, irq}, 32'h00000000);
		wr(CTRL_OFS, 32'h00000000);
		res(32'h00000002);
		chk(pend, 32'h00000082);
		res(32'h00000000);
		chk(pend, 32'h00000000);
	endtask

	task t_timer(input logic [3:0] p, input logic [15:0] rl);
		wr(IMASK_OFS, 32'h00000001);
		wr(RELOAD_OFS, {16'h0, rl});
		wr(CTRL_OFS, {23'h0, 1'b1, 4'h0, p});
		wr(CNTVAL_OFS, 32'h00001234);
		rdchk(CNTVAL_OFS, {16'h0, rl});
		cnt_ticks();
		chk(n, ({28'h0, p} + 32'h1) * {16'h0, rl});
		cyc(40);
		tick_on <= 1'b0;
		rdchk(CNTVAL_OFS, 32'h00000000);
		rdchk(ISTAT_OFS, 32'h00000001);
	endtask

	task t_event;
		wr(RELOAD_OFS, 32'h00000002);
		wr(CTRL_OFS, 32'h00000110);
		wr(CNTVAL_OFS, 32'h00000000);
		tick_on <= 1'b1;
		rx_event <= 1'b1;
		cyc(1);
		rx_event <= 1'b0;
		cyc(20);
		rdchk(CNTVAL_OFS, 32'h00000002);
		tick_on <= 1'b0;
		cyc(4);
		tx_event <= 1'b1;
		cyc(1);
		tx_event <= 1'b0;
		cyc(1);
		cnt_ticks();
		chk(n, 32'h00000002);
		tick_on <= 1'b0;
		rdchk(ISTAT_OFS, 32'h00000001);
		wr(CTRL_OFS, 32'h00000130);
		wr(CNTVAL_OFS, 32'h00000000);
		cyc(8);
		rdchk(CNTVAL_OFS, 32'h00000002);
		rx_event <= 1'b1;
		cyc(1);
		rx_event <= 1'b0;
		cnt_ticks();
		chk(n, 32'h00000002);
		tick_on <= 1'b0;
	endtask

	initial begin
		#200000;
		err_total++;
		test_done();
	end

	initial begin
		req = '0;
		presetn = 1'b0;
		tick_on = 1'b0;
		scan_hold = 1'b0;
		res_go = 1'b0;
		tx_event = 1'b0;
		rx_event = 1'b0;
		fail_sel = 32'h0;
		err_total = 0;
		compares = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_add();
		t_cancel();
		t_timer(4'h0, 16'h0002);
		t_timer(4'h2, 16'h0003);
		t_timer(4'hF, 16'h0002);
		t_event();
		test_done();
	end
endmodule
